// ==== inc/gpd_defs.vh ====
// Register indices, field layouts, reset values and mode codes of the pin port block
`ifndef GPD_DEFS_VH
`define GPD_DEFS_VH

// ============================================================
// Register indices (byte address is four times the index)
`define GPD_IDX_B_DATA 12'h0c04
`define GPD_IDX_B_FUNC 12'h0c06
`define GPD_IDX_C_DATA 12'h0c08
`define GPD_IDX_C_FUNC 12'h0c0a
`define GPD_IDX_D_DATA 12'h0c0c
`define GPD_IDX_D_FUNC 12'h0c0e

// ============================================================
// Bus layout
`define GPD_ADDR_W 14
`define GPD_IDX_LSB 2
`define GPD_REG_W 16

// ============================================================
// Reset values
`define GPD_RST_B_DATA 16'h0000
`define GPD_RST_B_FUNC 16'h0000
`define GPD_RST_C_DATA 16'h0000
`define GPD_RST_C_FUNC 16'h0000
`define GPD_RST_D_DATA 16'h0000
`define GPD_RST_D_FUNC 16'h0000

// ============================================================
// Writable bit masks; all other bits read as zero
`define GPD_MSK_B_DATA 16'h00f0
`define GPD_MSK_B_FUNC 16'hff00
`define GPD_MSK_C_DATA 16'h00ff
`define GPD_MSK_C_FUNC 16'hffff
`define GPD_MSK_D_DATA 16'h000f
`define GPD_MSK_D_FUNC 16'h00ff

// ============================================================
// Field positions
`define GPD_B_DATA_LSB 4
`define GPD_B_FUNC_LSB 8
`define GPD_C_DATA_LSB 0
`define GPD_C_FUNC_LSB 0
`define GPD_D_DATA_LSB 0
`define GPD_D_FUNC_LSB 0

// ============================================================
// Mode field codes
`define GPD_MODE_IN 2'h0
`define GPD_MODE_ALT1 2'h1
`define GPD_MODE_OUT 2'h2
`define GPD_MODE_RSV 2'h3

// ============================================================
// Pins on which alternate function one exists
`define GPD_ALT_B 4'h8
`define GPD_ALT_C 8'h00
`define GPD_ALT_D 4'h8

`endif

// ==== rtl/gpd_pin_slice.v ====
// Per-port pin multiplexer: mode decode, registered pin drive and data read-back
`include "gpd_defs.vh"

module gpd_pin_slice #(
	parameter N = 4,
	parameter [N-1:0] ALT_MASK = {N{1'b0}}
) (
	// Clock and reset
	input wire clk_i,
	input wire reset_i,
	// Register contents
	input wire [2*N-1:0] mode_i,
	input wire [N-1:0] data_i,
	// Alternate on-chip function
	input wire [N-1:0] alt_out_i,
	input wire [N-1:0] alt_oe_i,
	output wire [N-1:0] alt_in_o,
	// Pins
	input wire [N-1:0] pin_i,
	output reg [N-1:0] pin_o,
	output reg [N-1:0] pin_oe_o,
	// Read-back
	output reg [N-1:0] rd_o
);

	// ============================================================
	// Mode decode helpers
	function is_out;
		input [1:0] m;
		begin
			is_out = (m == `GPD_MODE_OUT);
		end
	endfunction

	function is_alt;
		input [1:0] m;
		input avail;
		begin
			is_alt = (m == `GPD_MODE_ALT1) && avail;
		end
	endfunction

	integer k;
	reg [N-1:0] drv_d;
	reg [N-1:0] oe_d;

	// The function always sees the pin level, whatever the mode
	assign alt_in_o = pin_i;

	// Next pin drive and read-back per pin
	always @*
	begin
		drv_d = {N{1'b0}};
		oe_d = {N{1'b0}};
		rd_o = {N{1'b0}};
		for (k = 0; k < N; k = k + 1)
		begin
			if (is_out(mode_i[2*k +: 2]))
			begin
				drv_d[k] = data_i[k]; // R8 R14
				oe_d[k] = 1'b1;
				rd_o[k] = data_i[k]; // R7 R13
			end
			else if (is_alt(mode_i[2*k +: 2], ALT_MASK[k]))
			begin
				drv_d[k] = alt_out_i[k]; // R18
				oe_d[k] = alt_oe_i[k]; // R18
				rd_o[k] = data_i[k]; // R18
			end
			else
			begin
				// Input, reserved codes, and alt on pins without one: no drive
				rd_o[k] = pin_i[k]; // R6 R12 R19
			end
		end
	end

	// Registered drive keeps pin outputs glitch free across mode writes
	always @(posedge clk_i)
	begin
		if (reset_i)
		begin
			pin_o <= {N{1'b0}};
			pin_oe_o <= {N{1'b0}};
		end
		else
		begin
			pin_o <= drv_d;
			pin_oe_o <= oe_d;
		end
	end

endmodule // gpd_pin_slice

// ==== rtl/gpd_ports.v ====
// Pin port block for ports B, C and D behind an Avalon-MM register slave
//
// Operation
// R1 - Port B modes in upper byte
// R2 - Port B codes: in, alt1, out, reserved
// R3 - Software avoids alt1 on B6..B4
// R4 - Port B function low byte zero
// R5 - Port C data at 0C08h, resets zero
// R6 - Port C input reads pin level
// R7 - Port C output reads stored bit
// R8 - Port C stored bit drives output pin
// R9 - Port C function at 0C0Ah, 2n+1:2n
// R10 - Port C codes: in, out, rest reserved
// R11 - Port D data at 0C0Ch, resets zero
// R12 - Port D input reads pin level
// R13 - Port D output reads stored bit
// R14 - Port D stored bit drives output pin
// R15 - Port D function at 0C0Eh, low byte
// R16 - Port D codes: in, alt1, out, reserved
// R17 - Software avoids alt1 on D2..D0
// R18 - Alt mode hands pin to function
// R19 - Input-mode write stores without driving
//
// The Avalon-MM register port was left to the implementer.
`include "gpd_defs.vh"

module gpd_ports (
	// Clock and reset
	input wire clk_i,
	input wire reset_i,
	// Avalon-MM slave
	input wire [`GPD_ADDR_W-1:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output wire avs_waitrequest_o,
	// Port B pins 7..4
	input wire [3:0] port_b_pins_i,
	output wire [3:0] port_b_pins_o,
	output wire [3:0] port_b_pins_oe_o,
	// Port B alternate function
	input wire [3:0] port_b_alt_out_i,
	input wire [3:0] port_b_alt_oe_i,
	output wire [3:0] port_b_alt_in_o,
	// Port C pins 7..0
	input wire [7:0] port_c_pins_i,
	output wire [7:0] port_c_pins_o,
	output wire [7:0] port_c_pins_oe_o,
	// Port D pins 3..0
	input wire [3:0] port_d_pins_i,
	output wire [3:0] port_d_pins_o,
	output wire [3:0] port_d_pins_oe_o,
	// Port D alternate function
	input wire [3:0] port_d_alt_out_i,
	input wire [3:0] port_d_alt_oe_i,
	output wire [3:0] port_d_alt_in_o
);

	// ============================================================
	// Helpers

	// Byte-lane merge of a 16-bit register, limited to its writable bits
	function [15:0] merge16;
		input [15:0] old;
		input [15:0] wdat;
		input [1:0] be;
		input [15:0] msk;
		reg [15:0] lane;
		begin
			lane = {{8{be[1]}}, {8{be[0]}}} & msk;
			merge16 = (old & ~lane) | (wdat & lane);
		end
	endfunction

	// Index match on the word address
	function hit;
		input [11:0] idx;
		input [11:0] want;
		begin
			hit = (idx == want);
		end
	endfunction

	// ============================================================
	// Bus handshake

	wire [11:0] idx;
	wire req;
	reg ack_q;
	wire wr_go;
	wire rd_go;

	assign idx = avs_address_i[`GPD_ADDR_W-1:`GPD_IDX_LSB];
	assign req = avs_read_i | avs_write_i;

	// One wait cycle on every access gives read data time to settle
	always @(posedge clk_i)
	begin
		if (reset_i)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q;
	end

	assign avs_waitrequest_o = req & ~ack_q;
	// Writes land only on the edge where waitrequest is low
	assign wr_go = avs_write_i & ack_q;
	// Read data is captured one edge before it is presented
	assign rd_go = avs_read_i & ~ack_q;

	// ============================================================
	// Registers

	reg [15:0] b_data_q;
	reg [15:0] b_func_q;
	reg [15:0] c_data_q;
	reg [15:0] c_func_q;
	reg [15:0] d_data_q;
	reg [15:0] d_func_q;
	wire [15:0] wdat;
	wire [1:0] be;

	assign wdat = avs_writedata_i[15:0];
	assign be = avs_byteenable_i[1:0];

	// Port B data; needed so port B output mode has a level to drive
	always @(posedge clk_i)
	begin
		if (reset_i)
			b_data_q <= `GPD_RST_B_DATA;
		else if (wr_go && hit(idx, `GPD_IDX_B_DATA))
			b_data_q <= merge16(b_data_q, wdat, be, `GPD_MSK_B_DATA);
	end

	// Port B function: modes in upper byte, low byte held at zero
	always @(posedge clk_i)
	begin
		if (reset_i)
			b_func_q <= `GPD_RST_B_FUNC; // R2 R4
		else if (wr_go && hit(idx, `GPD_IDX_B_FUNC))
			b_func_q <= merge16(b_func_q, wdat, be, `GPD_MSK_B_FUNC); // R1 R4
	end

	// Port C data; stored even while the pin is an input
	always @(posedge clk_i)
	begin
		if (reset_i)
			c_data_q <= `GPD_RST_C_DATA; // R5
		else if (wr_go && hit(idx, `GPD_IDX_C_DATA))
			c_data_q <= merge16(c_data_q, wdat, be, `GPD_MSK_C_DATA); // R5 R19
	end

	// Port C function fills all sixteen bits
	always @(posedge clk_i)
	begin
		if (reset_i)
			c_func_q <= `GPD_RST_C_FUNC; // R10
		else if (wr_go && hit(idx, `GPD_IDX_C_FUNC))
			c_func_q <= merge16(c_func_q, wdat, be, `GPD_MSK_C_FUNC); // R9
	end

	// Port D data, low nibble only
	always @(posedge clk_i)
	begin
		if (reset_i)
			d_data_q <= `GPD_RST_D_DATA; // R11
		else if (wr_go && hit(idx, `GPD_IDX_D_DATA))
			d_data_q <= merge16(d_data_q, wdat, be, `GPD_MSK_D_DATA); // R11 R19
	end

	// Port D function, low byte only
	always @(posedge clk_i)
	begin
		if (reset_i)
			d_func_q <= `GPD_RST_D_FUNC; // R15 R16
		else if (wr_go && hit(idx, `GPD_IDX_D_FUNC))
			d_func_q <= merge16(d_func_q, wdat, be, `GPD_MSK_D_FUNC); // R15
	end

	// ============================================================
	// Pin slices

	wire [3:0] b_rd;
	wire [7:0] c_rd;
	wire [3:0] d_rd;

	// Port B: alt one only on pin 7; code 01 on pins 6..4 acts as input
	gpd_pin_slice #(
		.N(4),
		.ALT_MASK(`GPD_ALT_B) // R3
	) u_port_b (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.mode_i(b_func_q[`GPD_B_FUNC_LSB +: 8]), // R1 R2
		.data_i(b_data_q[`GPD_B_DATA_LSB +: 4]),
		.alt_out_i(port_b_alt_out_i),
		.alt_oe_i(port_b_alt_oe_i),
		.alt_in_o(port_b_alt_in_o),
		.pin_i(port_b_pins_i),
		.pin_o(port_b_pins_o),
		.pin_oe_o(port_b_pins_oe_o),
		.rd_o(b_rd)
	);

	// Port C: no alternate function, reserved codes leave pin undriven
	gpd_pin_slice #(
		.N(8),
		.ALT_MASK(`GPD_ALT_C) // R10
	) u_port_c (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.mode_i(c_func_q[`GPD_C_FUNC_LSB +: 16]), // R9 R10
		.data_i(c_data_q[`GPD_C_DATA_LSB +: 8]), // R8
		.alt_out_i(8'h00),
		.alt_oe_i(8'h00),
		.alt_in_o(),
		.pin_i(port_c_pins_i),
		.pin_o(port_c_pins_o),
		.pin_oe_o(port_c_pins_oe_o),
		.rd_o(c_rd) // R6 R7
	);

	// Port D: alt one only on pin 3
	gpd_pin_slice #(
		.N(4),
		.ALT_MASK(`GPD_ALT_D) // R17
	) u_port_d (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.mode_i(d_func_q[`GPD_D_FUNC_LSB +: 8]), // R15 R16
		.data_i(d_data_q[`GPD_D_DATA_LSB +: 4]), // R14
		.alt_out_i(port_d_alt_out_i),
		.alt_oe_i(port_d_alt_oe_i),
		.alt_in_o(port_d_alt_in_o),
		.pin_i(port_d_pins_i),
		.pin_o(port_d_pins_o),
		.pin_oe_o(port_d_pins_oe_o),
		.rd_o(d_rd) // R12 R13
	);

	// ============================================================
	// Read path

	reg [15:0] rd_mux;

	// Data registers return pin or stored bit per mode; unmapped reads zero
	always @*
	begin
		case (idx)
			`GPD_IDX_B_DATA: rd_mux = {8'h00, b_rd, 4'h0};
			`GPD_IDX_B_FUNC: rd_mux = b_func_q & `GPD_MSK_B_FUNC; // R4
			`GPD_IDX_C_DATA: rd_mux = {8'h00, c_rd}; // R5 R6 R7
			`GPD_IDX_C_FUNC: rd_mux = c_func_q;
			`GPD_IDX_D_DATA: rd_mux = {12'h000, d_rd}; // R11 R12 R13
			`GPD_IDX_D_FUNC: rd_mux = d_func_q & `GPD_MSK_D_FUNC;
			default: rd_mux = 16'h0000;
		endcase
	end

	// Read data held until the next read is captured
	always @(posedge clk_i)
	begin
		if (reset_i)
			avs_readdata_o <= 32'h0000_0000;
		else if (rd_go)
			avs_readdata_o <= {16'h0000, rd_mux};
	end

endmodule // gpd_ports

// ==== sim/gpd_board.sv ====
// Board-side model of the port pins
module gpd_board #(
	parameter int N = 4
) (
	// Chip side and board pattern
	input wire logic [N-1:0] oe_i,
	input wire logic [N-1:0] out_i,
	input wire logic [N-1:0] pull_i,
	output logic [N-1:0] level_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Released pins show the board pattern, never the last driven level
	assign level_o = (oe_i & out_i) | (~oe_i & pull_i);
endmodule // gpd_board

// ==== sim/gpd_ports_monitor.sv ====
// Assertions on the ports of the pin port block
`include "gpd_defs.vh"
module gpd_ports_monitor (
	// Clock, reset and bus
	input wire clk_i,
	input wire reset_i,
	input wire [13:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	input wire [31:0] avs_readdata_o,
	input wire avs_waitrequest_o,
	// Pins
	input wire [3:0] port_b_pins_i,
	input wire [3:0] port_b_alt_in_o,
	input wire [7:0] port_c_pins_oe_o,
	input wire [3:0] port_d_pins_i,
	input wire [3:0] port_d_pins_o,
	input wire [3:0] port_d_pins_oe_o,
	input wire [3:0] port_d_alt_in_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// Helper flag for the port C mode write
	wire s_wr_flag = avs_write_i && !avs_waitrequest_o && avs_address_i[13:2] == `GPD_IDX_C_FUNC;
	// ============================================================
	// Write completing at this edge
	sequence s_wr(idx);
		avs_write_i && !avs_waitrequest_o && avs_address_i[13:2] == idx;
	endsequence
	// Pin drive lags the register by one edge, so results show two edges on
	chk_wait_once: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus wait longer than one cycle");
	chk_wait_idle: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
		else $error("wait raised with no request");
	chk_rdata_upper: assert property (avs_readdata_o[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	chk_c_oe_cause: assert property (!$stable(port_c_pins_oe_o) |-> $past(s_wr_flag, 2))
		else $error("port c enable moved without a mode write");
	chk_c_mode_oe: assert property (s_wr(`GPD_IDX_C_FUNC) ##0 avs_byteenable_i[0] |-> ##2 port_c_pins_oe_o[0] == $past(avs_writedata_i[1:0] == 2'h2, 2))
		else $error("port c pin 0 enable does not match mode");
	chk_d_drive: assert property (s_wr(`GPD_IDX_D_DATA) ##0 avs_byteenable_i[0] && port_d_pins_oe_o[1] |-> ##2 port_d_pins_o[1] == $past(avs_writedata_i[1], 2))
		else $error("port d pin 1 level does not follow data");
	chk_b_alt_in: assert property (port_b_alt_in_o == port_b_pins_i)
		else $error("port b function input differs from pins");
	chk_d_alt_in: assert property (port_d_alt_in_o == port_d_pins_i)
		else $error("port d function input differs from pins");
endmodule // gpd_ports_monitor

bind gpd_ports gpd_ports_monitor u_mon (.clk_i(clk_i), .reset_i(reset_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.port_b_pins_i(port_b_pins_i), .port_b_alt_in_o(port_b_alt_in_o),
	.port_c_pins_oe_o(port_c_pins_oe_o), .port_d_pins_i(port_d_pins_i),
	.port_d_pins_o(port_d_pins_o), .port_d_pins_oe_o(port_d_pins_oe_o),
	.port_d_alt_in_o(port_d_alt_in_o));

// ==== sim/gpd_ports_tb.sv ====
// Self-checking bench of the pin port block
module gpd_ports_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [13:0] avs_address_i = 14'h0000;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic [3:0] avs_byteenable_i = 4'hf;
	logic [3:0] b_alt_out = 4'h0;
	logic [3:0] b_alt_oe = 4'h0;
	logic [3:0] d_alt_out = 4'h0;
	logic [3:0] d_alt_oe = 4'h0;
	// Board pull pattern seen on released pins
	logic [3:0] b_pull = 4'h6;
	logic [7:0] c_pull = 8'h3c;
	logic [3:0] d_pull = 4'h5;
	wire [31:0] avs_readdata_o;
	wire avs_waitrequest_o;
	wire [3:0] b_in, b_out, b_oe, b_alt_in, d_in, d_out, d_oe, d_alt_in;
	wire [7:0] c_in, c_out, c_oe;
	logic [15:0] q;
	int errors = 0;
	int checked = 0;
	// ============================================================
	// Clock, design and board
	always #2.5 clk_i = ~clk_i;
	gpd_ports u_dut (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .port_b_pins_i(b_in), .port_b_pins_o(b_out),
		.port_b_pins_oe_o(b_oe), .port_b_alt_out_i(b_alt_out), .port_b_alt_oe_i(b_alt_oe),
		.port_b_alt_in_o(b_alt_in), .port_c_pins_i(c_in), .port_c_pins_o(c_out),
		.port_c_pins_oe_o(c_oe), .port_d_pins_i(d_in), .port_d_pins_o(d_out),
		.port_d_pins_oe_o(d_oe), .port_d_alt_out_i(d_alt_out), .port_d_alt_oe_i(d_alt_oe),
		.port_d_alt_in_o(d_alt_in));
	gpd_board #(.N(4)) u_brd_b (.oe_i(b_oe), .out_i(b_out), .pull_i(b_pull), .level_o(b_in));
	gpd_board #(.N(8)) u_brd_c (.oe_i(c_oe), .out_i(c_out), .pull_i(c_pull), .level_o(c_in));
	gpd_board #(.N(4)) u_brd_d (.oe_i(d_oe), .out_i(d_out), .pull_i(d_pull), .level_o(d_in));
	// ============================================================
	// Comparison, bus cycles and end of run
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	// Holds the request until wait drops; a slave that never answers is cut off
	task automatic bus(input logic w, input logic [13:0] a, input logic [15:0] d);
		int n;
		n = 0;
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= {16'h0000, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (avs_waitrequest_o !== 1'b0 && n < 50);
		if (n >= 50)
			errors++;
		q = avs_readdata_o[15:0];
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge clk_i);
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [13:0] a, input logic [15:0] exp, input string name);
		bus(1'b0, a, 16'h0000);
		chk(name, q, exp);
	endtask
	task automatic close_out;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ============================================================
	// Scenarios
	task automatic t_reset;
		rd(14'h3028, 16'h0000, "c func");
		rd(14'h3038, 16'h0000, "d func");
		rd(14'h3018, 16'h0000, "b func");
		rd(14'h3020, 16'h003c, "c data in");
		rd(14'h3030, 16'h0005, "d data in");
		rd(14'h3040, 16'h0000, "unmapped");
	endtask
	// Stored bits wait in input mode, reserved codes leave pins released
	task automatic t_port_c;
		bus(1'b1, 14'h3020, 16'hffa5);
		chk("c oe idle", {8'h00, c_oe}, 16'h0000);
		rd(14'h3020, 16'h003c, "c data in");
		bus(1'b1, 14'h3028, 16'haa5f);
		rd(14'h3028, 16'haa5f, "c func");
		chk("c oe", {8'h00, c_oe}, 16'h00f0);
		chk("c drive", {8'h00, c_out & c_oe}, 16'h00a0);
		rd(14'h3020, 16'h00ac, "c data mix");
	endtask
	// Pin 3 goes to the function, pins 2 and 1 drive, pin 0 listens
	task automatic t_port_d;
		d_alt_out <= 4'h0;
		d_alt_oe <= 4'h8;
		bus(1'b1, 14'h3038, 16'hff68);
		rd(14'h3038, 16'h0068, "d func");
		bus(1'b1, 14'h3030, 16'hfffa);
		chk("d oe", {12'h000, d_oe}, 16'h000e);
		chk("d drive", {12'h000, d_out & d_oe}, 16'h0002);
		rd(14'h3030, 16'h000b, "d data mix");
		d_alt_out <= 4'h8;
		@(posedge clk_i);
		@(posedge clk_i);
		chk("d alt out", {12'h000, d_out & d_oe}, 16'h000a);
	endtask
	// Pin 7 only is given to the function; pins 6..4 stay off it
	task automatic t_port_b;
		b_alt_out <= 4'h8;
		b_alt_oe <= 4'h8;
		bus(1'b1, 14'h3018, 16'h40ff);
		rd(14'h3018, 16'h4000, "b func");
		chk("b alt oe", {12'h000, b_oe}, 16'h0008);
		chk("b alt out", {12'h000, b_out & b_oe}, 16'h0008);
		bus(1'b1, 14'h3018, 16'h8000);
		chk("b out oe", {12'h000, b_oe}, 16'h0008);
		chk("b out lvl", {12'h000, b_out & b_oe}, 16'h0000);
		bus(1'b1, 14'h3010, 16'h0080);
		chk("b out hi", {12'h000, b_out & b_oe}, 16'h0008);
		rd(14'h3010, 16'h00e0, "b data mix");
		bus(1'b1, 14'h3018, 16'hc000);
		chk("b rsv oe", {12'h000, b_oe}, 16'h0000);
	endtask
	// ============================================================
	// Main sequence
	initial
	begin
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_port_c();
		t_port_d();
		t_port_b();
		close_out();
	end
	// Watchdog well past the ninety or so cycles the run needs
	initial
	begin
		#20000;
		errors++;
		close_out();
	end
endmodule // gpd_ports_tb
